/* pkg/gp_pkg.sv */
// constants, command codes and carriers for the 16-bit gpio port
package gp_pkg;
   localparam int          GP_WIDTH      = 16;
   localparam int          GP_IDX_W      = 4;
   localparam int          GP_BYTE_W     = 8;
   localparam logic [15:0] GP_WIDTH_VAL  = 16'h0010;
   localparam logic [15:0] GP_MASK_VAL   = 16'hFFFF;
   localparam logic [15:0] GP_DIR_RST    = 16'hFFFF;
   localparam logic [15:0] GP_LAT_RST    = 16'h0000;
   localparam logic [15:0] GP_ONE_HOT    = 16'h0001;
   localparam int          GP_SYNC_DEPTH = 3;

   // commands accepted on the request port
   typedef enum logic [3:0] {
      GP_OP_IN_ALL,
      GP_OP_IN_PIN,
      GP_OP_OUT_WR_ALL,
      GP_OP_OUT_WR_PIN,
      GP_OP_OUT_RD_ALL,
      GP_OP_OUT_RD_PIN,
      GP_OP_DATA_WR_ALL,
      GP_OP_DATA_RD_ALL,
      GP_OP_DATA_WR_PIN,
      GP_OP_DATA_RD_PIN,
      GP_OP_DIR_RD_ALL,
      GP_OP_DIR_RD_PIN,
      GP_OP_BUS_WR,
      GP_OP_WIDTH_RD,
      GP_OP_MASK_RD
   } gp_op_t;

   // one request: command, pin or half index, write data
   typedef struct packed {
      gp_op_t                op;
      logic [GP_IDX_W-1:0]   idx;
      logic [GP_WIDTH-1:0]   wdata;
   } gp_req_t;
endpackage

/* design/gp_sync.sv */
// three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module gp_sync #(
   parameter int W = 16
) (
   input  wire logic         core_clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // metastability chain; s1_r feeds only s2_r
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // accept a bit change once stages two and three agree
   always_ff @(posedge core_clk)
   begin
      if (srst)
         q <= '0;
      else
      begin
         for (int i = 0; i < W; i++)
            if (s2_r[i] == s3_r[i])
               q[i] <= s3_r[i];
      end
   end
endmodule
`default_nettype wire

/* design/gp_port.sv */
// 16-bit gpio port: direction, output latches, command port
// Functional notes
// R1 - pin input read forces pin input, returns level
// R2 - whole data write/read equals output/input
// R3 - pin data write/read equals pin output/input
// R4 - direction readback: 1 input, 0 output
// R5 - pin direction readback, no direction change
// R6 - byte write: index 0 low, 1 high
// R7 - output write drives all; latch read harmless
// R8 - width reads 16, mask reads all ones
// R9 - whole input read forces all inputs
`timescale 1ns/1ps
`default_nettype none
module gp_port (
   input  wire logic                         core_clk,
   input  wire logic                         srst,
   input  wire logic                         req_valid,
   input  wire gp_pkg::gp_req_t              req,
   output var  logic                         rsp_valid,
   output var  logic [gp_pkg::GP_WIDTH-1:0]  rsp_data,
   input  wire logic [gp_pkg::GP_WIDTH-1:0]  gpio_in,
   output var  logic [gp_pkg::GP_WIDTH-1:0]  gpio_out,
   output var  logic [gp_pkg::GP_WIDTH-1:0]  gpio_oe
);
   import gp_pkg::*;

   logic [GP_WIDTH-1:0] pin_s;
   logic [GP_WIDTH-1:0] dir_r;
   logic [GP_WIDTH-1:0] dir_nxt;
   logic [GP_WIDTH-1:0] lat_nxt;
   logic [GP_WIDTH-1:0] rd_nxt;
   logic                rd_en;
   logic [GP_WIDTH-1:0] bit_sel;

   // pin levels into the core clock
   gp_sync #(.W(GP_WIDTH)) u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (gpio_in),
      .q        (pin_s)
   );

   assign bit_sel = GP_ONE_HOT << req.idx;

   // decode one command into next direction, latch and answer
   always_comb
   begin
      dir_nxt = dir_r;
      lat_nxt = gpio_out;
      rd_nxt  = '0;
      rd_en   = 1'b0;
      if (req_valid)
      begin
         unique case (req.op)
            GP_OP_IN_ALL, GP_OP_DATA_RD_ALL:
            begin
               dir_nxt = GP_DIR_RST;                   // R9 R2
               rd_nxt  = pin_s;
               rd_en   = 1'b1;
            end
            GP_OP_IN_PIN, GP_OP_DATA_RD_PIN:
            begin
               dir_nxt = dir_r | bit_sel;              // R1 R3
               rd_nxt  = {15'h0000, pin_s[req.idx]};   // R1
               rd_en   = 1'b1;
            end
            GP_OP_OUT_WR_ALL, GP_OP_DATA_WR_ALL:
            begin
               dir_nxt = '0;                           // R7 R2
               lat_nxt = req.wdata;
            end
            GP_OP_OUT_WR_PIN, GP_OP_DATA_WR_PIN:
            begin
               dir_nxt = dir_r & ~bit_sel;             // R3
               lat_nxt = req.wdata[0] ? (gpio_out | bit_sel)
                                      : (gpio_out & ~bit_sel);
            end
            GP_OP_OUT_RD_ALL:
            begin
               rd_nxt = gpio_out;                      // R7
               rd_en  = 1'b1;
            end
            GP_OP_OUT_RD_PIN:
            begin
               rd_nxt = {15'h0000, gpio_out[req.idx]};
               rd_en  = 1'b1;
            end
            GP_OP_DIR_RD_ALL:
            begin
               rd_nxt = dir_r;                         // R4
               rd_en  = 1'b1;
            end
            GP_OP_DIR_RD_PIN:
            begin
               rd_nxt = {15'h0000, dir_r[req.idx]};    // R5
               rd_en  = 1'b1;
            end
            GP_OP_BUS_WR:
            begin
               if (req.idx[0])                         // R6
               begin
                  lat_nxt[15:8] = req.wdata[7:0];
                  dir_nxt[15:8] = 8'h00;
               end
               else
               begin
                  lat_nxt[7:0] = req.wdata[7:0];
                  dir_nxt[7:0] = 8'h00;
               end
            end
            GP_OP_WIDTH_RD:
            begin
               rd_nxt = GP_WIDTH_VAL;                  // R8
               rd_en  = 1'b1;
            end
            GP_OP_MASK_RD:
            begin
               rd_nxt = GP_MASK_VAL;                   // R8
               rd_en  = 1'b1;
            end
            default:
            begin
               rd_nxt = '0;
               rd_en  = 1'b0;
            end
         endcase
      end
   end

   // direction and drive enables, enable high while driving
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         dir_r   <= GP_DIR_RST;
         gpio_oe <= ~GP_DIR_RST;
      end
      else
      begin
         dir_r   <= dir_nxt;
         gpio_oe <= ~dir_nxt;
      end
   end

   // output latches
   always_ff @(posedge core_clk)
   begin
      if (srst)
         gpio_out <= GP_LAT_RST;
      else
         gpio_out <= lat_nxt;
   end

   // read answer, one cycle after the request
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
      end
      else
      begin
         rsp_valid <= rd_en;
         rsp_data  <= rd_nxt;
      end
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   a_pin_rd_dir: assert property (         // R1
      req_valid && req.op == GP_OP_IN_PIN |=>
      dir_r == ($past(dir_r) | (GP_ONE_HOT << $past(req.idx))))
      else $error("pin read did not set only that pin to input");

   a_pin_rd_data: assert property (        // R1
      req_valid && req.op == GP_OP_DATA_RD_PIN |=>
      rsp_valid && rsp_data == {15'h0000, $past(pin_s[req.idx])})
      else $error("pin read returned wrong level");

   a_data_wr_all: assert property (        // R2
      req_valid && req.op == GP_OP_DATA_WR_ALL |=>
      gpio_out == $past(req.wdata) && gpio_oe == GP_MASK_VAL)
      else $error("whole data write did not drive all pins");

   a_in_rd_all: assert property (          // R9
      req_valid && req.op == GP_OP_IN_ALL |=>
      dir_r == GP_DIR_RST && rsp_data == $past(pin_s) && gpio_oe == '0)
      else $error("whole input read wrong");

   a_pin_wr_dir: assert property (         // R3
      req_valid && req.op == GP_OP_DATA_WR_PIN |=>
      gpio_oe[$past(req.idx)] && !dir_r[$past(req.idx)] &&
      gpio_out[$past(req.idx)] == $past(req.wdata[0]))
      else $error("pin write did not drive the pin");

   a_dir_rd_all: assert property (         // R4
      req_valid && req.op == GP_OP_DIR_RD_ALL |=>
      rsp_data == $past(dir_r) && $stable(dir_r))
      else $error("direction readback wrong");

   a_dir_rd_pin: assert property (         // R5
      req_valid && req.op == GP_OP_DIR_RD_PIN |=>
      rsp_data[0] == $past(dir_r[req.idx]) && $stable(dir_r))
      else $error("pin direction readback wrong");

   a_bus_hi: assert property (             // R6
      req_valid && req.op == GP_OP_BUS_WR && req.idx[0] |=>
      gpio_out[15:8] == $past(req.wdata[7:0]) && $stable(gpio_out[7:0]))
      else $error("high byte write wrong");

   a_out_rd: assert property (             // R7
      req_valid && req.op == GP_OP_OUT_RD_ALL |=>
      rsp_data == $past(gpio_out) && $stable(gpio_oe))
      else $error("latch read wrong or changed direction");

   a_width_rd: assert property (           // R8
      req_valid && req.op == GP_OP_WIDTH_RD |=>
      rsp_valid && rsp_data == GP_WIDTH_VAL)
      else $error("width read wrong");

   c_pin_rd: cover property (req_valid && req.op == GP_OP_IN_PIN ##1 rsp_valid);
   c_bus_lo: cover property (req_valid && req.op == GP_OP_BUS_WR && !req.idx[0]);
   c_turn: cover property (req_valid && req.op == GP_OP_DATA_WR_ALL
                           ##1 req_valid && req.op == GP_OP_DATA_RD_ALL);
endmodule
`default_nettype wire

/* bench/tb_gp_port.sv */
// self-checking bench for the 16-bit gpio port
`timescale 1ns/1ps
`default_nettype none
module tb_gp_port;
   import gp_pkg::*;
   logic        core_clk = 1'b0;
   logic        srst     = 1'b1;
   logic        req_valid = 1'b0;
   gp_req_t     req      = '0;
   logic [15:0] gpio_in  = 16'h0000;
   logic        rsp_valid;
   logic [15:0] rsp_data;
   logic [15:0] gpio_out;
   logic [15:0] gpio_oe;
   int          num_errors = 0;
   int          check_count = 0;
   int          cycles = 0;

   gp_port i_gp_port (
      .core_clk  (core_clk),
      .srst      (srst),
      .req_valid (req_valid),
      .req       (req),
      .rsp_valid (rsp_valid),
      .rsp_data  (rsp_data),
      .gpio_in   (gpio_in),
      .gpio_out  (gpio_out),
      .gpio_oe   (gpio_oe)
   );

   // clock, 50 ns period
   initial
   begin
      forever #25 core_clk = ~core_clk;
   end

   // hang guard
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles > 2000)
      begin
         num_errors++;
         test_done();
      end
   end

   task automatic test_done();
      if (num_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one command, held from one falling edge to the next
   // strobe stays up between back-to-back calls; each call assigns it again
   task automatic cmd(input gp_op_t op, input logic [3:0] i,
                      input logic [15:0] w);
      req_valid = 1'b1;
      req = '{op: op, idx: i, wdata: w};
      @(negedge core_clk);
   endtask

   // read command: answer one cycle later, then drive enables
   task automatic rd(input gp_op_t op, input logic [3:0] i,
                     input logic [15:0] exp, input logic [15:0] oe);
      cmd(op, i, 16'h0000);
      chk({15'h0000, rsp_valid}, 16'h0001);
      chk(rsp_data, exp);
      chk(gpio_oe, oe);
   endtask

   // write command: no answer, latches and enables updated
   task automatic wr(input gp_op_t op, input logic [3:0] i,
                     input logic [15:0] w, input logic [15:0] out,
                     input logic [15:0] oe);
      cmd(op, i, w);
      chk({15'h0000, rsp_valid}, 16'h0000);
      chk(rsp_data, 16'h0000);
      chk(gpio_out, out);
      chk(gpio_oe, oe);
   endtask

   // reset state and constant reads
   task automatic t_reset();
      chk(gpio_out, 16'h0000);
      rd(GP_OP_DIR_RD_ALL, 4'h0, 16'hFFFF, 16'h0000);
      rd(GP_OP_WIDTH_RD, 4'h0, 16'h0010, 16'h0000);
      rd(GP_OP_MASK_RD, 4'h0, 16'hFFFF, 16'h0000);
   endtask

   // whole-bus writes and latch readback
   task automatic t_whole();
      wr(GP_OP_DATA_WR_ALL, 4'h0, 16'hA5C3, 16'hA5C3, 16'hFFFF);
      rd(GP_OP_OUT_RD_ALL, 4'h0, 16'hA5C3, 16'hFFFF);
      rd(GP_OP_DIR_RD_ALL, 4'h0, 16'h0000, 16'hFFFF);
   endtask

   // single-pin reads, direction readback and pin writes
   task automatic t_pin();
      req_valid = 1'b0;
      gpio_in = 16'h1234;
      repeat (6) @(negedge core_clk);
      rd(GP_OP_IN_PIN, 4'h4, 16'h0001, 16'hFFEF);
      rd(GP_OP_DIR_RD_PIN, 4'h4, 16'h0001, 16'hFFEF);
      rd(GP_OP_DIR_RD_PIN, 4'h5, 16'h0000, 16'hFFEF);
      rd(GP_OP_DIR_RD_ALL, 4'h0, 16'h0010, 16'hFFEF);
      rd(GP_OP_DATA_RD_PIN, 4'h2, 16'h0001, 16'hFFEB);
      rd(GP_OP_OUT_RD_PIN, 4'h7, 16'h0001, 16'hFFEB);
      wr(GP_OP_DATA_WR_PIN, 4'h4, 16'h0001, 16'hA5D3, 16'hFFFB);
      wr(GP_OP_OUT_WR_PIN, 4'h2, 16'h0001, 16'hA5D7, 16'hFFFF);
   endtask

   // whole input reads and byte writes to each half
   task automatic t_bus();
      rd(GP_OP_IN_ALL, 4'h0, 16'h1234, 16'h0000);
      wr(GP_OP_BUS_WR, 4'h0, 16'h003C, 16'hA53C, 16'h00FF);
      wr(GP_OP_BUS_WR, 4'h1, 16'h0081, 16'h813C, 16'hFFFF);
      rd(GP_OP_DATA_RD_ALL, 4'h0, 16'h1234, 16'h0000);
      rd(GP_OP_OUT_RD_ALL, 4'h0, 16'h813C, 16'h0000);
      wr(GP_OP_OUT_WR_ALL, 4'h0, 16'h0F0F, 16'h0F0F, 16'hFFFF);
      wr(GP_OP_DATA_WR_PIN, 4'h3, 16'h0000, 16'h0F07, 16'hFFFF);
      wr(gp_op_t'(4'hF), 4'h0, 16'hFFFF, 16'h0F07, 16'hFFFF);
   endtask

   // main sequence
   initial
   begin
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      @(negedge core_clk);
      t_reset();
      t_whole();
      t_pin();
      t_bus();
      test_done();
   end
endmodule
`default_nettype wire
